/* scc_stepper_chopper_control.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
// Operation
// (R01) sequencer advances only on rising edges of the step clock input
// (R02) direction input level selects forward or backward stepping
// (R03) three excitation select inputs choose full, half or microstep
// (R04) per-phase dac codes come from sequencer position
// (R05) internal timebase times off-time and blanking
// (R06) sync input high turns off chopping of both phases together
// (R07) controller avoids sync during normal stepping
// (R08) controller uses sync only when stopped at a 2-phase position
// (R09) coil open or short latches protection, disabling all outputs
// (R10) protection latch cleared only by logic supply cycling
// (R11) open detection only while phase is chopping under pwm
// (R12) over-temperature forces disable, same supply-cycle release
// (R13) trip comparator resets the pwm latch, output off
// (R14) driver stays off for fixed off-time after latch reset
// (R15) comparator ignored during blanking after turn-on
// (R16) on period never shorter than blanking interval
// (R17) each microstep clock moves the trip reference to next level
// (R18) microstep reference ratios follow a sinusoid
// (R19) option gives longer blanking interval
// (R20) full-scale mode uses 100 percent ratio with 12 us off-time
// (R21) off-time expiry sets latch again and restarts blanking
module scc_stepper_chopper_control (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_step_clock,
  input scc_pkg::scc_step_cfg_s i_step_cfg,
  input wire logic i_chop_sync,
  input wire logic i_enable,
  input wire logic [1:0] i_trip_threshold_voltage,
  input wire logic [1:0] i_coil_open,
  input wire logic [1:0] i_coil_short,
  input wire logic i_thermal_shutdown,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [3:0] o_phase_output,
  output scc_pkg::scc_dac_t o_dac_a,
  output scc_pkg::scc_dac_t o_dac_b,
  output logic o_protect
);
  // two-flop synchronisers for every pin input
  localparam int NS = 12;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sy1_q;
  logic [NS-1:0] sy2_q;
  assign pin_raw = {i_step_clock, i_step_cfg, i_chop_sync, i_enable, i_trip_threshold_voltage,
                    i_thermal_shutdown, |i_coil_open, |i_coil_short};
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else begin
      sy1_q <= pin_raw;
      sy2_q <= sy1_q;
    end
  end
  logic step_s;
  logic dir_s;
  logic [2:0] mode_s;
  logic sync_s;
  logic en_s;
  logic [1:0] trip_s;
  logic thermal_s;
  logic open_s;
  logic short_s;
  assign {step_s, dir_s, mode_s, sync_s, en_s, trip_s, thermal_s, open_s, short_s} = sy2_q;

  // step edge detect on synchronised copy only
  logic step_prev_q;
  logic step_rise;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_s;
    end
  end
  assign step_rise = step_s && !step_prev_q;

  // step increment per mode: 000 full, 001 half, 010 quarter, 011 eighth, else sixteenth
  logic [6:0] inc;
  always_comb begin
    case (mode_s)
      3'b000: inc = 7'd16;
      3'b001: inc = 7'd8;
      3'b010: inc = 7'd4;
      3'b011: inc = 7'd2;
      default: inc = 7'd1;
    endcase
  end

  // position in 64 sixteenth-steps per electrical cycle
  logic [5:0] pos_q;
  logic [5:0] pos_d;
  always_comb begin
    // (R02) direction picks sign
    if (dir_s) begin
      pos_d = 6'(pos_q - inc[5:0]);
    end else begin
      pos_d = 6'(pos_q + inc[5:0]);
    end
  end
  // (R01) single step clock; (R03) mode sets stride
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_q <= 6'h08;
    end else if (step_rise && !o_protect) begin
      // full step stays on odd 2-phase points
      pos_q <= (mode_s == 3'b000) ? {pos_d[5:4], 4'h8} : pos_d;
    end
  end

  // (R18) sine table; (R04) phase a uses sin, b uses cos
  scc_pkg::scc_dac_t sin_a;
  scc_pkg::scc_dac_t sin_b;
  logic [5:0] pos_b;
  assign pos_b = 6'(pos_q + 6'd16);
  scc_sine_rom u_rom_a (
    .i_ref_clk(i_ref_clk),
    .i_addr(pos_q),
    .o_data(sin_a)
  );
  scc_sine_rom u_rom_b (
    .i_ref_clk(i_ref_clk),
    .i_addr(pos_b),
    .o_data(sin_b)
  );
  logic [1:0] pos_quad_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_quad_q <= 2'b00;
    end else begin
      pos_quad_q <= {pos_q[5], pos_b[5]};
    end
  end

  // control register
  logic [31:0] ctrl_q;
  logic long_blank;
  assign long_blank = ctrl_q[`SCC_CTRL_LONGBLANK];

  // (R09) (R10) (R12) protection latch, only async reset (supply) clears it
  logic open_q;
  logic short_q;
  logic thermal_q;
  logic [1:0] drive;
  logic [1:0] blank;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      open_q <= 1'b0;
      short_q <= 1'b0;
      thermal_q <= 1'b0;
    end else begin
      // (R11) open only counted while chopping
      if (open_s && (|drive) && !(&blank)) begin
        open_q <= 1'b1;
      end
      if (short_s) begin
        short_q <= 1'b1;
      end
      if (thermal_s) begin
        thermal_q <= 1'b1;
      end
    end
  end
  logic fault;
  assign fault = open_q || short_q || thermal_q;

  // (R05) (R06) (R19) two choppers share timebase, sync, blank option
  logic run;
  assign run = en_s && !fault;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ph
      scc_chopper u_chop (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_enable(run),
        .i_trip(trip_s[g]),
        .i_sync_off(sync_s),
        .i_long_blank(long_blank),
        .o_drive(drive[g]),
        .o_blanking(blank[g])
      );
    end
  endgenerate

  // registered outputs: phase pairs a,/a,b,/b
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_phase_output <= 4'h0;
      o_protect <= 1'b0;
      o_dac_a <= 8'h00;
      o_dac_b <= 8'h00;
    end else begin
      // (R09) fault blanks every driver
      o_protect <= fault;
      o_phase_output <= fault ? 4'h0 : {drive[1] && pos_quad_q[0], drive[1] && !pos_quad_q[0],
                                        drive[0] && pos_quad_q[1], drive[0] && !pos_quad_q[1]};
      // (R17) reference follows position; (R20) full step runs at full scale
      if (mode_s == 3'b000) begin
        o_dac_a <= `SCC_FULL_SCALE;
        o_dac_b <= `SCC_FULL_SCALE;
      end else begin
        o_dac_a <= sin_a;
        o_dac_b <= sin_b;
      end
    end
  end

  // avalon slave, one wait state per access
  logic pend_q;
  logic acc;
  assign acc = i_avs_read || i_avs_write;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_q <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
      ctrl_q <= `SCC_CTRL_RESET;
    end else begin
      pend_q <= acc && !pend_q;
      o_avs_waitrequest <= !(acc && !pend_q);
      if (acc && !pend_q) begin
        if (i_avs_address == `SCC_CTRL_OFS) begin
          o_avs_readdata <= ctrl_q;
          if (i_avs_write && i_avs_byteenable[0]) begin
            ctrl_q <= {31'h0, i_avs_writedata[0]};
          end
        end else if (i_avs_address == `SCC_STAT_OFS) begin
          o_avs_readdata <= {24'h0, pos_q, thermal_q, fault ? 1'b1 : open_q || short_q};
        end else if (i_avs_address == `SCC_DAC_OFS) begin
          o_avs_readdata <= {16'h0, o_dac_b, o_dac_a};
        end else begin
          o_avs_readdata <= 32'h00000000;
        end
      end
    end
  end

  // (R10) latch holds while reset stays released
  prot_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_protect |=> o_protect)
    else $error("protection released without supply cycle");
  // (R09) outputs off after fault
  fault_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    fault |=> o_phase_output == 4'h0)
    else $error("driver active under protection");
  // (R12) thermal forces protect
  thermal_prot_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    thermal_s |=> ##1 o_protect)
    else $error("thermal did not disable outputs");
  // (R06) sync ends the drive[0] on period once past blanking
  sync_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sync_s && drive[0] && !blank[0] && run |=> !drive[0])
    else $error("sync did not stop chopping");
  // (R01) position moves only after step edge
  step_only_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !step_rise |=> $stable(pos_q))
    else $error("position moved without step");
  // (R20) full step full scale
  full_scale_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    mode_s == 3'b000 |=> o_dac_a == `SCC_FULL_SCALE)
    else $error("full step not at full scale");
endmodule : scc_stepper_chopper_control

/* scc_regs.svh */
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH
// avalon register offsets (byte addresses)
`define SCC_CTRL_OFS 8'h00
`define SCC_STAT_OFS 8'h04
`define SCC_DAC_OFS 8'h08
// control register fields
`define SCC_CTRL_LONGBLANK 0
`define SCC_CTRL_RESET 32'h00000000
// timing, 250 MHz reference
`define SCC_CLK_MHZ 250
`define SCC_OFF_NS 12000
`define SCC_OFF_CYC ((`SCC_OFF_NS * `SCC_CLK_MHZ) / 1000)
`define SCC_BLANK_SHORT_NS 1000
`define SCC_BLANK_LONG_NS 2000
`define SCC_BLANK_SHORT_CYC ((`SCC_BLANK_SHORT_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_BLANK_LONG_CYC ((`SCC_BLANK_LONG_NS * `SCC_CLK_MHZ + 999) / 1000)
`define SCC_FULL_SCALE 8'hff
`endif

/* scc_pkg.sv */
package scc_pkg;
  typedef enum logic [2:0] {
    SCC_CH_DRIVE = 3'b001,
    SCC_CH_OFF = 3'b010,
    SCC_CH_HALT = 3'b100
  } scc_chop_e;
  typedef struct packed {
    logic rotation_direction_select;
    logic excitation_select_2;
    logic excitation_select_1;
    logic excitation_select_0;
  } scc_step_cfg_s;
  typedef logic [7:0] scc_dac_t;
endpackage : scc_pkg

/* scc_sine_rom.sv */
`timescale 1ns/1ps
// sine reference table, registered read
module scc_sine_rom (
  input wire logic i_ref_clk,
  input wire logic [5:0] i_addr,
  output scc_pkg::scc_dac_t o_data
);
  scc_pkg::scc_dac_t mem [0:16];
  scc_pkg::scc_dac_t data_q;
  logic [5:0] a;
  assign mem[0] = 8'h00;
  assign mem[1] = 8'h19;
  assign mem[2] = 8'h32;
  assign mem[3] = 8'h4a;
  assign mem[4] = 8'h62;
  assign mem[5] = 8'h78;
  assign mem[6] = 8'h8e;
  assign mem[7] = 8'ha2;
  assign mem[8] = 8'hb4;
  assign mem[9] = 8'hc5;
  assign mem[10] = 8'hd4;
  assign mem[11] = 8'he1;
  assign mem[12] = 8'hec;
  assign mem[13] = 8'hf4;
  assign mem[14] = 8'hfa;
  assign mem[15] = 8'hfe;
  assign mem[16] = 8'hff;
  // quarter wave folded: 0..16 rising, 17..31 falling
  assign a = (i_addr[4:0] > 5'd16) ? 6'(6'd32 - {1'b0, i_addr[4:0]}) : {1'b0, i_addr[4:0]};
  always_ff @(posedge i_ref_clk) begin
    data_q <= mem[a[4:0]];
  end
  assign o_data = data_q;
endmodule : scc_sine_rom

/* scc_chopper.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
// one phase fixed off-time chopper
module scc_chopper (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_trip,
  input wire logic i_sync_off,
  input wire logic i_long_blank,
  output logic o_drive,
  output logic o_blanking
);
  scc_pkg::scc_chop_e st_q;
  logic [11:0] cnt_q;
  logic [11:0] blank_len;
  localparam logic [11:0] OFF_CYC = 12'(`SCC_OFF_CYC);
  assign blank_len = i_long_blank ? 12'(`SCC_BLANK_LONG_CYC) : 12'(`SCC_BLANK_SHORT_CYC);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= scc_pkg::SCC_CH_HALT;
      cnt_q <= 12'h000;
    end else begin
      case (st_q)
        scc_pkg::SCC_CH_HALT: begin
          if (i_enable) begin
            st_q <= scc_pkg::SCC_CH_DRIVE;
            cnt_q <= 12'h000;
          end
        end
        scc_pkg::SCC_CH_DRIVE: begin
          if (!i_enable) begin
            st_q <= scc_pkg::SCC_CH_HALT;
          // (R13) trip resets latch; (R15) ignored in blanking
          end else if ((cnt_q >= blank_len) && (i_trip || i_sync_off)) begin
            st_q <= scc_pkg::SCC_CH_OFF;
            cnt_q <= 12'h000;
          end else if (cnt_q < blank_len) begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        scc_pkg::SCC_CH_OFF: begin
          if (!i_enable) begin
            st_q <= scc_pkg::SCC_CH_HALT;
          // (R14) fixed off-time; (R21) relatch and reblank
          end else if (cnt_q >= OFF_CYC - 12'h001) begin
            st_q <= scc_pkg::SCC_CH_DRIVE;
            cnt_q <= 12'h000;
          end else begin
            cnt_q <= cnt_q + 12'h001;
          end
        end
        default: st_q <= scc_pkg::SCC_CH_HALT;
      endcase
    end
  end
  assign o_drive = (st_q == scc_pkg::SCC_CH_DRIVE);
  assign o_blanking = (st_q == scc_pkg::SCC_CH_DRIVE) && (cnt_q < blank_len);
  // (R16) minimum on-time
  min_on_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (st_q == scc_pkg::SCC_CH_DRIVE) && (cnt_q < blank_len) && i_enable |=> st_q == scc_pkg::SCC_CH_DRIVE)
    else $error("on period ended inside blanking");
  // (R14) off holds for at least 8 cycles
  off_time_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(st_q == scc_pkg::SCC_CH_OFF) && i_enable |-> (st_q == scc_pkg::SCC_CH_OFF) [*8])
    else $error("off time cut short");
endmodule : scc_chopper

/* scc_host_model.sv */
`timescale 1ns/1ps
// controller side: one step clock per request
module scc_host_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_step_req,
  output logic o_step_clock,
  output logic o_busy
);
  logic [3:0] cnt_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) cnt_q <= 4'h0;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    else if (i_step_req) cnt_q <= 4'hf;
  end
  // high 8 low 7, wide enough for the two-flop pin sync
  assign o_step_clock = cnt_q[3];
  assign o_busy = cnt_q != 4'h0;
endmodule : scc_host_model

/* scc_stepper_chopper_control_tb_top.sv */
`timescale 1ns/1ps
`include "scc_regs.svh"
module scc_stepper_chopper_control_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic req = 1'b0;
  logic stp;
  logic busy;
  scc_pkg::scc_step_cfg_s cfg = '0;
  logic sync = 1'b0;
  logic en = 1'b0;
  logic [1:0] trip = 2'h0;
  logic [1:0] opn = 2'h0;
  logic [1:0] sht = 2'h0;
  logic hot = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wait_r;
  logic [3:0] ph;
  scc_pkg::scc_dac_t dac_a;
  scc_pkg::scc_dac_t dac_b;
  logic prot;
  int errors = 0;
  int comparisons = 0;
  initial begin
    forever #2 clk = ~clk;
  end
  scc_host_model scc_host_model_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_step_req(req), .o_step_clock(stp),
    .o_busy(busy));
  scc_stepper_chopper_control scc_stepper_chopper_control_i (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_step_clock(stp), .i_step_cfg(cfg), .i_chop_sync(sync), .i_enable(en), .i_trip_threshold_voltage(trip),
    .i_coil_open(opn), .i_coil_short(sht), .i_thermal_shutdown(hot), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_r), .o_phase_output(ph), .o_dac_a(dac_a), .o_dac_b(dac_b), .o_protect(prot));
  task report_and_stop;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task av(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    // no cycle count assumed: only the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (wait_r !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : av
  task do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset
  task step;
    @(posedge clk);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1) @(posedge clk);
    repeat (10) @(posedge clk);
  endtask : step
  task phase_times(output int on_c, output int off_c);
    off_c = 0;
    while (ph[1:0] !== 2'b00 && off_c < 9000) @(posedge clk);
    while (ph[1:0] === 2'b00) @(posedge clk);
    on_c = 0;
    while (ph[1:0] !== 2'b00 && on_c < 9000) begin
      @(posedge clk);
      on_c++;
    end
    off_c = 0;
    while (ph[1:0] === 2'b00 && off_c < 9000) begin
      @(posedge clk);
      off_c++;
    end
  endtask : phase_times
  function automatic logic near(input int a, input int b);
    return a >= b - 3 && a <= b + 3;
  endfunction : near
  task t_reset;
    logic [31:0] q;
    // reset values looked at while reset still holds them
    chk({wait_r, prot, ph, dac_a, dac_b}, {1'b1, 21'h0});
    rst_n <= 1'b1;
    av(1'b0, `SCC_CTRL_OFS, 32'h0, q);
    chk(q, `SCC_CTRL_RESET);
    av(1'b1, 8'h3c, 32'hffffffff, q);
    av(1'b0, 8'h3c, 32'h0, q);
    chk(q, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task t_step;
    logic [31:0] q0;
    logic [31:0] q1;
    logic [5:0] inc;
    for (int m = 0; m < 5; m++) begin
      for (int d = 0; d < 2; d++) begin
        inc = 6'h10 >> m;
        cfg <= {d[0], m[2:0]};
        repeat (8) @(posedge clk);
        av(1'b0, `SCC_STAT_OFS, 32'h0, q0);
        step();
        av(1'b0, `SCC_STAT_OFS, 32'h0, q1);
        chk(q1[7:2], 6'(d ? q0[7:2] - inc : q0[7:2] + inc));
        if (m == 0) chk({dac_b, dac_a}, {`SCC_FULL_SCALE, `SCC_FULL_SCALE});
        // back on a 2-phase point: both phases at sin 45 deg of full scale
        if (m != 0 && d == 1) chk({dac_b, dac_a}, 16'hb4b4);
      end
    end
    $display("test step done");
  endtask : t_step
  task t_chop;
    int on_c;
    int off_c;
    logic [31:0] q;
    cfg <= '0;
    en <= 1'b1;
    trip <= 2'b11;
    phase_times(on_c, off_c);
    chk(near(on_c, `SCC_BLANK_SHORT_CYC), 1'b1);
    chk(near(off_c, `SCC_OFF_CYC), 1'b1);
    av(1'b1, `SCC_CTRL_OFS, 32'h1, q);
    av(1'b0, `SCC_CTRL_OFS, 32'h0, q);
    chk(q, 32'h1);
    phase_times(on_c, off_c);
    phase_times(on_c, off_c);
    chk(near(on_c, `SCC_BLANK_LONG_CYC), 1'b1);
    av(1'b1, `SCC_CTRL_OFS, 32'h0, q);
    $display("test chop done");
  endtask : t_chop
  task t_sync;
    int n;
    trip <= 2'b00;
    // stopped at a full-step position before asserting sync
    sync <= 1'b1;
    // let the current on period end, then time a fresh one that only sync can end
    n = 0;
    while (ph[1:0] !== 2'b00 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (ph[1:0] === 2'b00 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (ph[1:0] !== 2'b00 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(ph, 4'h0);
    chk(n >= `SCC_BLANK_SHORT_CYC && n < 600, 1'b1);
    sync <= 1'b0;
    $display("test sync done");
  endtask : t_sync
  task t_fault;
    logic [31:0] q;
    for (int k = 0; k < 3; k++) begin
      do_reset();
      en <= 1'b1;
      repeat (400) @(posedge clk);
      sht <= {1'b0, k == 0};
      opn <= {1'b0, k == 1};
      hot <= k == 2;
      repeat (20) @(posedge clk);
      {sht, opn, hot} <= '0;
      repeat (20) @(posedge clk);
      chk({prot, ph}, 5'h10);
      av(1'b0, `SCC_STAT_OFS, 32'h0, q);
      chk(q[1:0], k == 2 ? 2'b11 : 2'b01);
    end
    do_reset();
    @(posedge clk);
    chk(prot, 1'b0);
    $display("test fault done");
  endtask : t_fault
  initial begin
    repeat (5) @(posedge clk);
    t_reset();
    t_step();
    t_chop();
    t_sync();
    t_fault();
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    report_and_stop();
  end
endmodule : scc_stepper_chopper_control_tb_top
